/* File: hw/dbt_pkg.sv */
// constants, types and helpers shared by the transceiver and its test access port
// assumes the importing modules run the test logic on the test clock and the pins on the system clock
package dbt_pkg;

	localparam int GRP_W = 9;
	localparam int NUM_GRP = 2;
	localparam int CHAIN_LEN = 80;
	localparam int IR_LEN = 8;
	localparam int ID_LEN = 32;
	localparam int BYP_LEN = 1;

	// chain layout: four control cells per group, then four runs of nine cells per group
	localparam int CHN_CTL_HI = 79;
	localparam int CHN_CTL_STRIDE = 4;
	localparam int CHN_AIN_HI = 71;
	localparam int CHN_BOUT_HI = 53;
	localparam int CHN_BIN_HI = 35;
	localparam int CHN_AOUT_HI = 17;
	localparam int OFS_FLOW = 0;
	localparam int OFS_EN_N = 1;
	localparam int OFS_AOE = 2;
	localparam int OFS_BOE = 3;

	// ones mark the controlling cells: per-side enables and all output cells
	localparam logic [CHAIN_LEN-1:0] CTRL_MASK = {8'h33, 18'h0, 18'h3ffff, 18'h0, 18'h3ffff};
	localparam logic [CHAIN_LEN-1:0] CHAIN_RST = 80'h0;

	localparam logic [IR_LEN-1:0] OP_EXTEST = 8'h00;
	localparam logic [IR_LEN-1:0] OP_SAMPLE = 8'h81;
	localparam logic [IR_LEN-1:0] OP_CLAMP = 8'h82;
	localparam logic [IR_LEN-1:0] OP_HIGHZ = 8'h03;
	localparam logic [IR_LEN-1:0] OP_SAMPLE_IN = 8'h41;
	localparam logic [IR_LEN-1:0] OP_SAMPLE_OUT = 8'h42;
	localparam logic [IR_LEN-1:0] OP_OUTPUT_ONLY_EXTERNAL_TEST = 8'h22;
	localparam logic [IR_LEN-1:0] OP_IDENTIFICATION_REG = 8'haa;
	localparam logic [IR_LEN-1:0] OP_BYPASS = 8'hff;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = OP_SAMPLE;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} dbt_tap_e;

	typedef enum logic [3:0] {
		I_EXTEST, I_SAMPLE, I_CLAMP, I_HIGHZ, I_SAMPLE_IN, I_SAMPLE_OUT, I_OUTPUT_ONLY_EXTERNAL_TEST, I_IDENTIFICATION_REG, I_BYPASS
	} dbt_instr_e;

	typedef struct packed {
		logic [NUM_GRP-1:0] flow;
		logic [NUM_GRP-1:0] en_n;
		logic [NUM_GRP-1:0][GRP_W-1:0] left;
		logic [NUM_GRP-1:0][GRP_W-1:0] right;
	} dbt_pins_s;

	typedef struct packed {
		logic drive_test;
		logic force_hiz;
		logic [CHAIN_LEN-1:0] cells;
	} dbt_ctl_s;

	function automatic dbt_instr_e dbt_decode(input logic [IR_LEN-1:0] op);
		dbt_instr_e r;
		case (op)
			OP_EXTEST: r = I_EXTEST;
			OP_SAMPLE: r = I_SAMPLE;
			OP_CLAMP: r = I_CLAMP;
			OP_HIGHZ: r = I_HIGHZ;
			OP_SAMPLE_IN: r = I_SAMPLE_IN;
			OP_SAMPLE_OUT: r = I_SAMPLE_OUT;
			OP_OUTPUT_ONLY_EXTERNAL_TEST: r = I_OUTPUT_ONLY_EXTERNAL_TEST;
			OP_IDENTIFICATION_REG: r = I_IDENTIFICATION_REG;
			default: r = I_BYPASS;
		endcase
		return r;
	endfunction

	// system values as seen by every cell of the chain
	function automatic logic [CHAIN_LEN-1:0] dbt_chain_vec(input dbt_pins_s p, input logic [NUM_GRP-1:0] a_side_drive_en,
		input logic [NUM_GRP-1:0] b_side_drive_en);
		logic [CHAIN_LEN-1:0] v;
		v = CHAIN_RST;
		for (int g = 0; g < NUM_GRP; g++)
		begin
			v[CHN_CTL_HI - CHN_CTL_STRIDE*g - OFS_FLOW] = p.flow[g];
			v[CHN_CTL_HI - CHN_CTL_STRIDE*g - OFS_EN_N] = p.en_n[g];
			v[CHN_CTL_HI - CHN_CTL_STRIDE*g - OFS_AOE] = a_side_drive_en[g];
			v[CHN_CTL_HI - CHN_CTL_STRIDE*g - OFS_BOE] = b_side_drive_en[g];
			for (int i = 0; i < GRP_W; i++)
			begin
				v[CHN_AIN_HI - GRP_W*g - i] = p.left[g][i];
				v[CHN_BOUT_HI - GRP_W*g - i] = p.left[g][i];
				v[CHN_BIN_HI - GRP_W*g - i] = p.right[g][i];
				v[CHN_AOUT_HI - GRP_W*g - i] = p.right[g][i];
			end
		end
		return v;
	endfunction

	// shift toward bit 0, tdi enters at the top of the selected length
	function automatic logic [CHAIN_LEN-1:0] dbt_shift(input logic [CHAIN_LEN-1:0] v, input logic tdi,
		input int len);
		logic [CHAIN_LEN-1:0] r;
		r = v >> 1;
		r[len-1] = tdi;
		return r;
	endfunction

endpackage

/* File: hw/dbt_tap_fsm.sv */
// sixteen-state test access port controller
// assumes tck_in is the test clock and rst_n_in a reset already released in step with it
`timescale 1ns/100ps
module dbt_tap_fsm
	import dbt_pkg::*;
(
	input wire logic tck_in,
	input wire logic rst_n_in,
	input wire logic tms_in,
	output dbt_tap_e state_out
);

	dbt_tap_e st_r;
	dbt_tap_e st_nxt;

	always_comb
	begin
		unique case (st_r)
			TAP_RESET: st_nxt = tms_in ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: st_nxt = tms_in ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: st_nxt = tms_in ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: st_nxt = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: st_nxt = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: st_nxt = tms_in ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: st_nxt = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: st_nxt = tms_in ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: st_nxt = tms_in ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: st_nxt = tms_in ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: st_nxt = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: st_nxt = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: st_nxt = tms_in ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: st_nxt = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: st_nxt = tms_in ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: st_nxt = tms_in ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	always_ff @(posedge tck_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= TAP_RESET;
		else
			st_r <= st_nxt;
	end

	assign state_out = st_r;

endmodule

/* File: hw/dbt_xcvr_top.sv */
// two nine-bit transceiver groups wrapped in a boundary-scan test access port
// assumes pins are asynchronous to sys_clk_in and the test clock keeps running a few edges after each update
// Notes on behaviour
// - two nine-bit groups, each with its own enable and direction select
// - enabled group drives B onto A when select low, A onto B when high
// - enable input high puts both sides of that group in high impedance
// - outputs only enable after the enable input goes from inactive to active
// - input pins get observe cells; outputs and both side enables get controlling cells
// - observe cells only sample; controlling cells also substitute updated values in test
// - active-high side enables gate A and B outputs; a loaded one activates them
// - bypass is one shift stage capturing zero
// - identification word is version, entity, part, maker, then a fixed one
// - eight-bit instruction register captures the sample/preload opcode
// - capture, exit-1, update without shifting makes sample/preload active
// - zero code is external test, 82h is clamp, 03h is high impedance
// - input-only sample, output-only sample and output-only external test are decoded
// - AAh selects identification; all-ones and unknown codes select bypass
// - chain bits 79 to 72 are direction, enable, A-enable, B-enable per group
// - chain bits 71 to 54 observe A-side inputs, group one first
// - chain bits 53 to 36 control B-side outputs, group one first
// - chain bits 35 to 18 observe B-side inputs, group one first
// - chain bits 17 to 0 control A-side outputs, group one first
// - after reset outputs stay off until each enable input sees a falling edge
`timescale 1ns/100ps
module dbt_xcvr_top
	import dbt_pkg::*;
#(
	parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
	parameter logic [5:0] ID_ENTITY = 6'h05, // arbitrary value
	parameter logic [9:0] ID_PART = 10'h0a5, // arbitrary value
	parameter logic [10:0] ID_MAKER = 11'h2a5 // arbitrary value
)
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic flow_select_grp1_in,
	input wire logic flow_select_grp2_in,
	input wire logic drive_en_n_grp1_in,
	input wire logic drive_en_n_grp2_in,
	input wire logic [8:0] left_port_grp1_in,
	output logic [8:0] left_port_grp1_out,
	output logic [8:0] left_port_grp1_oe_out,
	input wire logic [8:0] right_port_grp1_in,
	output logic [8:0] right_port_grp1_out,
	output logic [8:0] right_port_grp1_oe_out,
	input wire logic [8:0] left_port_grp2_in,
	output logic [8:0] left_port_grp2_out,
	output logic [8:0] left_port_grp2_oe_out,
	input wire logic [8:0] right_port_grp2_in,
	output logic [8:0] right_port_grp2_out,
	output logic [8:0] right_port_grp2_oe_out,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_out
);

	localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_ENTITY, ID_PART, ID_MAKER, 1'b1};

	// system clock domain state
	typedef struct packed {
		dbt_pins_s pin_s1;
		dbt_pins_s pin_s2;
		logic [NUM_GRP-1:0] en_prev;
		logic [NUM_GRP-1:0] armed;
		logic [NUM_GRP-1:0][GRP_W-1:0] left_dat;
		logic [NUM_GRP-1:0][GRP_W-1:0] left_oe;
		logic [NUM_GRP-1:0][GRP_W-1:0] right_dat;
		logic [NUM_GRP-1:0][GRP_W-1:0] right_oe;
		logic [CHAIN_LEN-1:0] snap;
		logic snap_tgl;
		logic snap_ack_s1;
		logic snap_ack_s2;
		logic req_s1;
		logic req_s2;
		logic ctl_ack;
		dbt_ctl_s ctl;
	} dbt_sys_s;

	// test clock domain state
	typedef struct packed {
		logic [IR_LEN-1:0] ir_sh;
		logic [IR_LEN-1:0] ir;
		logic [CHAIN_LEN-1:0] dr_sh;
		logic [CHAIN_LEN-1:0] upd;
		logic snap_s1;
		logic snap_s2;
		logic snap_ack;
		logic [CHAIN_LEN-1:0] snap_copy;
		logic send_req;
		logic ack_s1;
		logic ack_s2;
		dbt_ctl_s send;
	} dbt_tck_s;

	dbt_sys_s sys_r;
	dbt_sys_s sys_nxt;
	dbt_tck_s tk_r;
	dbt_tck_s tk_nxt;
	dbt_tap_e tap_st;
	dbt_pins_s pins_raw;
	logic [1:0] trst_sync_r;
	logic tck_rst_n;
	logic tdo_r;
	logic tdo_oe_r;

	assign pins_raw.flow = {flow_select_grp2_in, flow_select_grp1_in};
	assign pins_raw.en_n = {drive_en_n_grp2_in, drive_en_n_grp1_in};
	assign pins_raw.left = {left_port_grp2_in, left_port_grp1_in};
	assign pins_raw.right = {right_port_grp2_in, right_port_grp1_in};

	// system side: synchronise pins, arm enables, drive outputs, trade words with the test side
	always_comb
	begin
		logic [NUM_GRP-1:0] en_eff;
		logic [NUM_GRP-1:0] a_side_drive_en;
		logic [NUM_GRP-1:0] b_side_drive_en;
		logic [NUM_GRP-1:0] sys_aoe;
		logic [NUM_GRP-1:0] sys_boe;
		en_eff = '0;
		a_side_drive_en = '0;
		b_side_drive_en = '0;
		sys_aoe = '0;
		sys_boe = '0;
		sys_nxt = sys_r;
		sys_nxt.pin_s1 = pins_raw;
		sys_nxt.pin_s2 = sys_r.pin_s1;
		sys_nxt.en_prev = sys_r.pin_s2.en_n;
		for (int g = 0; g < NUM_GRP; g++)
		begin
			// a low level held since reset is not enough; only a falling edge arms the group
			if (sys_r.en_prev[g] && !sys_r.pin_s2.en_n[g])
				sys_nxt.armed[g] = 1'b1;
			en_eff[g] = sys_r.armed[g] && !sys_r.pin_s2.en_n[g];
			sys_aoe[g] = en_eff[g] && !sys_r.pin_s2.flow[g];
			sys_boe[g] = en_eff[g] && sys_r.pin_s2.flow[g];
			if (sys_r.ctl.force_hiz)
			begin
				a_side_drive_en[g] = 1'b0;
				b_side_drive_en[g] = 1'b0;
			end
			else if (sys_r.ctl.drive_test)
			begin
				a_side_drive_en[g] = sys_r.ctl.cells[CHN_CTL_HI - CHN_CTL_STRIDE*g - OFS_AOE];
				b_side_drive_en[g] = sys_r.ctl.cells[CHN_CTL_HI - CHN_CTL_STRIDE*g - OFS_BOE];
			end
			else
			begin
				a_side_drive_en[g] = sys_aoe[g];
				b_side_drive_en[g] = sys_boe[g];
			end
			sys_nxt.left_oe[g] = {GRP_W{a_side_drive_en[g]}};
			sys_nxt.right_oe[g] = {GRP_W{b_side_drive_en[g]}};
			for (int i = 0; i < GRP_W; i++)
			begin
				if (sys_r.ctl.drive_test)
				begin
					sys_nxt.left_dat[g][i] = sys_r.ctl.cells[CHN_AOUT_HI - GRP_W*g - i];
					sys_nxt.right_dat[g][i] = sys_r.ctl.cells[CHN_BOUT_HI - GRP_W*g - i];
				end
				else
				begin
					sys_nxt.left_dat[g][i] = sys_r.pin_s2.right[g][i];
					sys_nxt.right_dat[g][i] = sys_r.pin_s2.left[g][i];
				end
			end
		end
		// snapshot handshake: the word holds still until the test side has acknowledged it
		sys_nxt.snap_ack_s1 = tk_r.snap_ack;
		sys_nxt.snap_ack_s2 = sys_r.snap_ack_s1;
		if (sys_r.snap_tgl == sys_r.snap_ack_s2)
		begin
			sys_nxt.snap = dbt_chain_vec(sys_r.pin_s2, sys_aoe, sys_boe);
			sys_nxt.snap_tgl = !sys_r.snap_tgl;
		end
		// control word from the test side, taken once its request toggle is seen
		sys_nxt.req_s1 = tk_r.send_req;
		sys_nxt.req_s2 = sys_r.req_s1;
		if (sys_r.req_s2 != sys_r.ctl_ack)
		begin
			sys_nxt.ctl = tk_r.send;
			sys_nxt.ctl_ack = sys_r.req_s2;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			sys_r <= '0;
		else
			sys_r <= sys_nxt;
	end

	// test-side reset: asserted at once, released on the test clock
	always_ff @(posedge tck_in or negedge resetn_in)
	begin
		if (!resetn_in)
			trst_sync_r <= 2'h0;
		else
			trst_sync_r <= {trst_sync_r[0], 1'b1};
	end

	assign tck_rst_n = trst_sync_r[1];

	dbt_tap_fsm u_tap (
		.tck_in(tck_in),
		.rst_n_in(tck_rst_n),
		.tms_in(tms_in),
		.state_out(tap_st)
	);

	// test side: instruction and data registers, update register, crossings
	always_comb
	begin
		dbt_instr_e ins;
		logic [CHAIN_LEN-1:0] cap_mask;
		int dr_len;
		dbt_ctl_s cur;
		cur = '0;
		ins = dbt_decode(tk_r.ir);
		cap_mask = '1;
		dr_len = BYP_LEN;
		tk_nxt = tk_r;
		unique case (ins)
			I_EXTEST, I_SAMPLE, I_OUTPUT_ONLY_EXTERNAL_TEST, I_SAMPLE_IN, I_SAMPLE_OUT: dr_len = CHAIN_LEN;
			I_IDENTIFICATION_REG: dr_len = ID_LEN;
			I_CLAMP, I_HIGHZ, I_BYPASS: dr_len = BYP_LEN;
		endcase
		// restricted instructions leave the other cells' shift stages untouched
		if (ins == I_SAMPLE_IN)
			cap_mask = ~CTRL_MASK;
		else if (ins == I_SAMPLE_OUT || ins == I_OUTPUT_ONLY_EXTERNAL_TEST)
			cap_mask = CTRL_MASK;
		if (tap_st == TAP_RESET)
			tk_nxt.ir = OP_IDENTIFICATION_REG;
		else if (tap_st == TAP_CAP_IR)
			tk_nxt.ir_sh = IR_CAPTURE;
		else if (tap_st == TAP_SHIFT_IR)
			tk_nxt.ir_sh = {tdi_in, tk_r.ir_sh[IR_LEN-1:1]};
		else if (tap_st == TAP_UPD_IR)
			tk_nxt.ir = tk_r.ir_sh;
		else if (tap_st == TAP_CAP_DR)
		begin
			if (dr_len == CHAIN_LEN)
				tk_nxt.dr_sh = (tk_r.dr_sh & ~cap_mask) | (tk_r.snap_copy & cap_mask);
			else if (dr_len == ID_LEN)
				tk_nxt.dr_sh = {{(CHAIN_LEN-ID_LEN){1'b0}}, ID_WORD};
			else
				tk_nxt.dr_sh = '0;
		end
		else if (tap_st == TAP_SHIFT_DR)
			tk_nxt.dr_sh = dbt_shift(tk_r.dr_sh, tdi_in, dr_len);
		else if (tap_st == TAP_UPD_DR && dr_len == CHAIN_LEN)
			tk_nxt.upd = tk_r.dr_sh;
		// take the latest pin snapshot whenever the system side offers one
		tk_nxt.snap_s1 = sys_r.snap_tgl;
		tk_nxt.snap_s2 = tk_r.snap_s1;
		if (tk_r.snap_s2 != tk_r.snap_ack)
		begin
			tk_nxt.snap_copy = sys_r.snap;
			tk_nxt.snap_ack = tk_r.snap_s2;
		end
		cur.drive_test = (ins == I_EXTEST) || (ins == I_CLAMP) || (ins == I_OUTPUT_ONLY_EXTERNAL_TEST);
		cur.force_hiz = (ins == I_HIGHZ);
		cur.cells = tk_r.upd;
		// the word is only resent once the previous one has been acknowledged
		tk_nxt.ack_s1 = sys_r.ctl_ack;
		tk_nxt.ack_s2 = tk_r.ack_s1;
		if (tk_r.send_req == tk_r.ack_s2 && tk_r.send != cur)
		begin
			tk_nxt.send = cur;
			tk_nxt.send_req = !tk_r.send_req;
		end
	end

	always_ff @(posedge tck_in or negedge tck_rst_n)
	begin
		if (!tck_rst_n)
		begin
			tk_r <= '0;
			tk_r.ir <= OP_IDENTIFICATION_REG;
		end
		else
			tk_r <= tk_nxt;
	end

	// test data out changes on the falling edge, as the far side samples on the rising edge
	always_ff @(negedge tck_in or negedge tck_rst_n)
	begin
		if (!tck_rst_n)
		begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end
		else
		begin
			tdo_r <= (tap_st == TAP_SHIFT_IR) ? tk_r.ir_sh[0] : tk_r.dr_sh[0];
			tdo_oe_r <= (tap_st == TAP_SHIFT_IR) || (tap_st == TAP_SHIFT_DR);
		end
	end

	assign tdo_out = tdo_r;
	assign tdo_oe_out = tdo_oe_r;
	assign left_port_grp1_out = sys_r.left_dat[0];
	assign left_port_grp1_oe_out = sys_r.left_oe[0];
	assign right_port_grp1_out = sys_r.right_dat[0];
	assign right_port_grp1_oe_out = sys_r.right_oe[0];
	assign left_port_grp2_out = sys_r.left_dat[1];
	assign left_port_grp2_oe_out = sys_r.left_oe[1];
	assign right_port_grp2_out = sys_r.right_dat[1];
	assign right_port_grp2_oe_out = sys_r.right_oe[1];

endmodule

/* File: tb/dbt_xcvr_asserts.sv */
// checker for the transceiver pins and the test data out enable
// assumes it is bound into dbt_xcvr_top and sees only its ports
`timescale 1ns/100ps
module dbt_xcvr_asserts
	import dbt_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic drive_en_n_grp1_in,
	input wire logic [8:0] left_port_grp1_in,
	input wire logic [8:0] left_port_grp1_oe_out,
	input wire logic [8:0] right_port_grp1_out,
	input wire logic [8:0] right_port_grp1_oe_out,
	input wire logic [8:0] right_port_grp2_in,
	input wire logic [8:0] left_port_grp2_out,
	input wire logic [8:0] left_port_grp2_oe_out,
	input wire logic [8:0] right_port_grp2_oe_out,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdo_oe_out
);
	// pins are in normal mode from a long stay in reset until the instruction path is entered
	logic [3:0] ones_r;
	logic seen_r;
	dbt_tap_e trk_r;
	logic ir_used_r;
	wire nrm = !ir_used_r;
	wire [35:0] oes = {left_port_grp1_oe_out, right_port_grp1_oe_out, left_port_grp2_oe_out, right_port_grp2_oe_out};
	always_ff @(posedge tck_in or negedge resetn_in)
		if (!resetn_in)
			ones_r <= 4'h8;
		else
			ones_r <= !tms_in ? 4'h0 : ((ones_r == 4'h8) ? ones_r : ones_r + 4'h1);
	// own mirror of the port state machine; clearing waits for eight highs so the reset word has crossed
	always_ff @(posedge tck_in or negedge resetn_in)
		if (!resetn_in)
			trk_r <= TAP_RESET;
		else
			unique case (trk_r)
				TAP_RESET: trk_r <= tms_in ? TAP_RESET : TAP_IDLE;
				TAP_IDLE: trk_r <= tms_in ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: trk_r <= tms_in ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: trk_r <= tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
				TAP_SHIFT_DR: trk_r <= tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
				TAP_EXIT1_DR: trk_r <= tms_in ? TAP_UPD_DR : TAP_PAUSE_DR;
				TAP_PAUSE_DR: trk_r <= tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
				TAP_EXIT2_DR: trk_r <= tms_in ? TAP_UPD_DR : TAP_SHIFT_DR;
				TAP_UPD_DR: trk_r <= tms_in ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR: trk_r <= tms_in ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: trk_r <= tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
				TAP_SHIFT_IR: trk_r <= tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
				TAP_EXIT1_IR: trk_r <= tms_in ? TAP_UPD_IR : TAP_PAUSE_IR;
				TAP_PAUSE_IR: trk_r <= tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
				TAP_EXIT2_IR: trk_r <= tms_in ? TAP_UPD_IR : TAP_SHIFT_IR;
				TAP_UPD_IR: trk_r <= tms_in ? TAP_SEL_DR : TAP_IDLE;
			endcase
	always_ff @(posedge tck_in or negedge resetn_in)
		if (!resetn_in)
			ir_used_r <= 1'b0;
		else if (trk_r == TAP_SEL_IR)
			ir_used_r <= 1'b1;
		else if (ones_r == 4'h8)
			ir_used_r <= 1'b0;
	// a high level must come before any falling edge can arm group one
	always_ff @(posedge sys_clk_in or negedge resetn_in)
		if (!resetn_in)
			seen_r <= 1'b0;
		else
			seen_r <= seen_r | drive_en_n_grp1_in;
	sequence s_norm;
		nrm [*6];
	endsequence
	a_hiz_when_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		s_norm ##0 drive_en_n_grp1_in [*4] |-> (left_port_grp1_oe_out | right_port_grp1_oe_out) == 9'h0)
		else $error("group one drives while disabled");
	a_flow_a_to_b: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		s_norm ##0 (right_port_grp1_oe_out == 9'h1ff) [*4] |-> right_port_grp1_out == $past(left_port_grp1_in, 3))
		else $error("right side does not follow left side");
	a_flow_b_to_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		s_norm ##0 (left_port_grp2_oe_out == 9'h1ff) [*4] |-> left_port_grp2_out == $past(right_port_grp2_in, 3))
		else $error("left side does not follow right side");
	a_side_uniform: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		left_port_grp1_oe_out inside {9'h0, 9'h1ff} && right_port_grp1_oe_out inside {9'h0, 9'h1ff}
		&& left_port_grp2_oe_out inside {9'h0, 9'h1ff} && right_port_grp2_oe_out inside {9'h0, 9'h1ff})
		else $error("side enable split within a group");
	a_one_side_only: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		s_norm |-> !(|left_port_grp1_oe_out && |right_port_grp1_oe_out) && !(|left_port_grp2_oe_out && |right_port_grp2_oe_out))
		else $error("both sides driven in normal mode");
	a_reset_quiet: assert property (@(posedge sys_clk_in) !resetn_in |-> oes == 36'h0 && !tdo_oe_out)
		else $error("drive during reset");
	a_arm_on_fall: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		nrm && !seen_r |-> (left_port_grp1_oe_out | right_port_grp1_oe_out) == 9'h0)
		else $error("group one driven without a falling enable");
	a_tdo_only_shift: assert property (@(posedge tck_in) disable iff (!resetn_in)
		ones_r >= 4'h2 |-> !tdo_oe_out)
		else $error("test data out driven outside shift");
endmodule

bind dbt_xcvr_top dbt_xcvr_asserts u_chk (.sys_clk_in, .resetn_in, .drive_en_n_grp1_in, .left_port_grp1_in,
	.left_port_grp1_oe_out, .right_port_grp1_out, .right_port_grp1_oe_out, .right_port_grp2_in,
	.left_port_grp2_out, .left_port_grp2_oe_out, .right_port_grp2_oe_out, .tck_in, .tms_in, .tdo_oe_out);

/* File: tb/dbt_jtag_ctl.sv */
// test controller model driving the test access port
// assumes each scan starts in run-test/idle; tck stands low outside scans
`timescale 1ns/100ps
module dbt_jtag_ctl (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in,
	input wire logic tdo_oe_in
);
	logic last_r = 1'b0;
	// a released line shows the inverse of its last level, so stale data never matches
	wire tdo_line = tdo_oe_in ? tdo_in : !last_r;
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	task automatic tick(input logic m, input logic d, output logic q);
		tms_out = m;
		tdi_out = d;
		#3 tck_out = 1'b1;
		q = tdo_line;
		last_r = tdo_line;
		#3 tck_out = 1'b0;
	endtask
	task automatic tap_reset();
		logic q;
		repeat (12) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
	task automatic ir_capture_only();
		logic q;
		for (int i = 0; i < 6; i++)
			tick(i inside {0, 1, 3, 4}, 1'b0, q);
		repeat (7) tick(1'b0, 1'b0, q);
	endtask
	task automatic scan(input logic ir, input logic [79:0] din, input int len, output logic [79:0] dout);
		logic q;
		dout = 80'h0;
		tick(1'b1, 1'b0, q);
		if (ir)
			tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < len; i++)
		begin
			tick(i == len - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, 1'b0, q);
		repeat (7) tick(1'b0, 1'b0, q);
	endtask
endmodule

/* File: tb/tb_dual_byte_transceiver_bscan.sv */
// self-checking bench for the transceiver groups and their test access port
// assumes dbt_jtag_ctl drives the test pins; pin levels merge bench and design drive
`timescale 1ns/100ps
module tb_dual_byte_transceiver_bscan
	import dbt_pkg::*;
;
	localparam logic [31:0] EXP_ID = {4'h3, 6'h11, 10'h155, 11'h0aa, 1'b1}; // arbitrary identity values
	localparam logic [7:0] OPS [7] = '{OP_CLAMP, OP_HIGHZ, OP_BYPASS, 8'h5a, OP_OUTPUT_ONLY_EXTERNAL_TEST, OP_SAMPLE_IN, OP_SAMPLE_OUT};
	localparam logic [17:0] OES [7] = '{18'h3fe00, 18'h0, 18'h1ff, 18'h1ff, 18'h3fe00, 18'h1ff, 18'h1ff};
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b1;
	logic [1:0] flow = 2'b01;
	logic [1:0] en_n = 2'b00;
	logic [8:0] l1 = 9'h0, r1 = 9'h155, l2 = 9'h0, r2 = 9'h0;
	wire [8:0] l1o, l1e, r1o, r1e, l2o, l2e, r2o, r2e;
	wire tck, tms, tdi, tdo, tdo_oe;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [31:0] rnd = 32'hc6da6fed;
	logic [79:0] q, p;
	always #2.5 sys_clk_in = !sys_clk_in;
	dbt_xcvr_top #(.ID_VERSION(4'h3), .ID_ENTITY(6'h11), .ID_PART(10'h155), .ID_MAKER(11'h0aa)) dut (
		.sys_clk_in, .resetn_in, .flow_select_grp1_in(flow[0]), .flow_select_grp2_in(flow[1]),
		.drive_en_n_grp1_in(en_n[0]), .drive_en_n_grp2_in(en_n[1]),
		.left_port_grp1_in((l1e & l1o) | (~l1e & l1)), .left_port_grp1_out(l1o), .left_port_grp1_oe_out(l1e),
		.right_port_grp1_in((r1e & r1o) | (~r1e & r1)), .right_port_grp1_out(r1o), .right_port_grp1_oe_out(r1e),
		.left_port_grp2_in((l2e & l2o) | (~l2e & l2)), .left_port_grp2_out(l2o), .left_port_grp2_oe_out(l2e),
		.right_port_grp2_in((r2e & r2o) | (~r2e & r2)), .right_port_grp2_out(r2o), .right_port_grp2_oe_out(r2e),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe));
	dbt_jtag_ctl jtag (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [79:0] exp_chain(input logic [1:0] f, input logic [1:0] e, input logic [1:0] ao,
		input logic [1:0] bo, input logic [1:0][8:0] a, input logic [1:0][8:0] b);
		logic [79:0] v;
		v = 80'h0;
		for (int g = 0; g < 2; g++)
		begin
			v[79 - 4*g] = f[g];
			v[78 - 4*g] = e[g];
			v[77 - 4*g] = ao[g];
			v[76 - 4*g] = bo[g];
			for (int i = 0; i < 9; i++)
			begin
				v[71 - 9*g - i] = a[g][i];
				v[53 - 9*g - i] = a[g][i];
				v[35 - 9*g - i] = b[g][i];
				v[17 - 9*g - i] = b[g][i];
			end
		end
		return v;
	endfunction
	task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			conclude();
		end
	end
	initial
	begin
		// a real falling edge, so the asynchronous reset branches fire at start-up
		#1 resetn_in = 1'b0;
		pause(5);
		resetn_in = 1'b1;
		pause(10);
		check("oe_no_fall", {l1e, r1e, l2e, r2e}, 36'h0);
		jtag.tap_reset();
		en_n = 2'b11;
		pause(4);
		en_n = 2'b00;
		pause(8);
		// all-ones and all-zeros first, then random words
		for (int k = 0; k < 8; k++)
		begin
			rnd = lfsr(rnd);
			l1 = (k == 0) ? 9'h1ff : rnd[8:0];
			r2 = (k == 0) ? 9'h0 : rnd[20:12];
			pause(5);
			check("a_to_b", {r1e, r1o, l1e}, {9'h1ff, l1, 9'h0});
			check("b_to_a", {l2e, l2o, r2e}, {9'h1ff, r2, 9'h0});
		end
		en_n = 2'b01;
		pause(5);
		check("off", {l1e, r1e, l2e}, {18'h0, 9'h1ff});
		jtag.scan(1'b0, 80'h0, 32, q);
		check("identification_reg", q[31:0], EXP_ID);
		jtag.ir_capture_only();
		rnd = lfsr(rnd);
		p = 80'h0;
		p[76] = 1'b1;
		for (int i = 0; i < 9; i++)
			p[53 - i] = rnd[i];
		jtag.scan(1'b0, p, 80, q);
		check("chain", q, exp_chain(2'b01, 2'b01, 2'b10, 2'b00, {r2, l1}, {r2, r1}));
		jtag.scan(1'b1, {72'h0, OP_EXTEST}, 8, q);
		check("ir_capture", q[7:0], 8'h81);
		pause(10);
		check("extest", {r1e, r1o, l1e, l2e, r2e}, {9'h1ff, rnd[8:0], 27'h0});
		check("extest_dat", {l1o, l2o, r2o}, 27'h0);
		for (int k = 0; k < 7; k++)
		begin
			jtag.scan(1'b1, {72'h0, OPS[k]}, 8, q);
			pause(10);
			check("op_oe", {r1e, l2e}, OES[k]);
			if (k < 4)
			begin
				jtag.scan(1'b0, 80'h3, 2, q);
				check("bypass", q[1:0], 2'b10);
			end
		end
		jtag.tap_reset();
		pause(10);
		check("normal", {r1e, l2e}, 18'h1ff);
		resetn_in = 1'b0;
		pause(2);
		resetn_in = 1'b1;
		pause(10);
		check("rearm", {l2e, r2e}, 18'h0);
		conclude();
	end
endmodule
